// *** core/capture_irq_pkg.sv ***
// capture unit interrupt flag block: constants, modes and carriers
// assumes one 10 MHz system clock and an AHB-Lite register bus
package capture_irq_pkg;

    localparam int UNIT_COUNT = 5;
    localparam int FLAG_WIDTH = 8;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] EVENT_FLAGS_OFFSET = 12'h000;
    localparam logic [11:0] UNIT_ENABLE_OFFSET = 12'h004;
    localparam logic [11:0] INT_CONTROL_OFFSET = 12'h008;
    localparam logic [11:0] UNIT_MODE_OFFSET = 12'h00C;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h1F;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam int PERIPH_ENABLE_BIT = 6;
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    localparam int MODE_FIELD_WIDTH = 2;
    localparam logic [9:0] MODE_RESET = 10'h000;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_PULSE
    } unit_mode_type;

    // per-unit event strobes from the units
    typedef struct packed {
        logic [UNIT_COUNT-1:0] capture;
        logic [UNIT_COUNT-1:0] match;
        logic [UNIT_COUNT-1:0] pulseOut;
    } unit_events_type;

endpackage

// *** core/unit_event_detect.sv ***
// one unit's flag set source, chosen by the unit mode
// assumes event strobes synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module unit_event_detect (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // unit side
    input wire logic [1:0] unitMode,
    input wire logic captureEvent,
    input wire logic matchEvent,
    input wire logic pulseOut,
    // flag side
    output logic setPulse
);
    import capture_irq_pkg::*;

    logic pulseLast_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pulseLast_reg <= 1'b0;
        end else begin
            pulseLast_reg <= pulseOut;
        end
    end

    always_comb begin
        case (unit_mode_type'(unitMode))
            MODE_CAPTURE: setPulse = captureEvent;
            MODE_COMPARE: setPulse = matchEvent;
            MODE_PULSE: setPulse = pulseLast_reg && !pulseOut;
            default: setPulse = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** core/capture_unit_irq_flags.sv ***
// event flag register for five capture/compare/pulse units
// assumes AHB-Lite master, single word transfers, synchronous inputs
//
// Behaviour
// - bits 7 to 5 read zero and ignore writes.
// - bits 0 to 4 hold the flags of units one to five.
// - in capture mode a capture sets the unit flag until cleared.
// - in compare mode a match sets the unit flag until cleared.
// - in pulse mode the output trailing edge sets the flag.
// - flags set only from events; hardware never clears them.
// - software reads flags and clears them; hardware can still set.
// - every flag is zero after any reset.
// - flags set regardless of unit, peripheral or global enables.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module capture_unit_irq_flags #(
    parameter int UNITS = capture_irq_pkg::UNIT_COUNT
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // unit events
    input wire capture_irq_pkg::unit_events_type unitEvents,
    // interrupt to the core
    output logic interruptRequest
);
    import capture_irq_pkg::*;

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] enable_reg;
    logic [1:0] control_reg;
    logic [9:0] mode_reg;
    logic [11:0] addr_reg;
    logic writePending_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic readyOut_reg;
    logic [1:0] resp_reg;
    logic [UNITS-1:0] setEvent;
    logic addrPhase;
    logic writeNow;
    logic readNow;
    logic [7:0] clearMask;

    // ----------------------------------------------------------------
    // per-unit event sources
    // ----------------------------------------------------------------
    genvar u;
    generate
        for (u = 0; u < UNITS; u++) begin : gen_unit
            unit_event_detect detect (
                .clock(clock),
                .reset_n(reset_n),
                .unitMode(mode_reg[u*MODE_FIELD_WIDTH +: MODE_FIELD_WIDTH]),
                .captureEvent(unitEvents.capture[u]),
                .matchEvent(unitEvents.match[u]),
                .pulseOut(unitEvents.pulseOut[u]),
                .setPulse(setEvent[u])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign writeNow = writePending_reg;
    assign readNow = addrPhase && !hwrite;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= 12'h000;
            writePending_reg <= 1'b0;
        end else begin
            writePending_reg <= addrPhase && hwrite;
            if (addrPhase) begin
                addr_reg <= haddr[11:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    always_comb begin
        clearMask = 8'h00;
        if (writeNow && addr_reg == EVENT_FLAGS_OFFSET) begin
            clearMask = ~hwdata[7:0];
        end
        flags_next = flags_reg & ~clearMask;
        flags_next[UNITS-1:0] = flags_next[UNITS-1:0] | setEvent;
        flags_next = flags_next & FLAG_IMPL_MASK;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= FLAG_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ----------------------------------------------------------------
    // enables and modes
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable_reg <= ENABLE_RESET;
            control_reg <= CONTROL_RESET;
            mode_reg <= MODE_RESET;
        end else if (writeNow) begin
            case (addr_reg)
                UNIT_ENABLE_OFFSET: enable_reg <= hwdata[7:0] & FLAG_IMPL_MASK;
                INT_CONTROL_OFFSET: begin
                    control_reg <= {hwdata[GLOBAL_ENABLE_BIT], hwdata[PERIPH_ENABLE_BIT]};
                end
                UNIT_MODE_OFFSET: mode_reg <= hwdata[9:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (readNow) begin
            case (haddr[11:0])
                EVENT_FLAGS_OFFSET: rdata_reg <= {24'h00_0000, flags_reg};
                UNIT_ENABLE_OFFSET: rdata_reg <= {24'h00_0000, enable_reg};
                INT_CONTROL_OFFSET: rdata_reg <= {24'h00_0000, control_reg, 6'h00};
                UNIT_MODE_OFFSET: rdata_reg <= {22'h00_0000, mode_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    // zero wait states and an OKAY answer, both held in flip-flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readyOut_reg <= 1'b1;
            resp_reg <= HRESP_OKAY;
        end else begin
            readyOut_reg <= 1'b1;
            resp_reg <= HRESP_OKAY;
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = readyOut_reg;
    assign hresp = resp_reg;

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (|(flags_next & enable_reg)) && control_reg[1] && control_reg[0];
        end
    end

    assign interruptRequest = irq_reg;
endmodule
`default_nettype wire

// *** test/capture_irq_sva.sv ***
// checker on the flag block ports
// assumes a bind onto capture_unit_irq_flags
`timescale 1ns/1ps
`default_nettype none
module capture_irq_sva #(
    parameter int UNITS = capture_irq_pkg::UNIT_COUNT
) (
    // bus and unit side
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire capture_irq_pkg::unit_events_type unitEvents,
    input wire logic interruptRequest
);
    import capture_irq_pkg::*;
    wire logic tk = hsel && hready && htrans == HTRANS_NONSEQ;
    logic [2:0] ph;
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n) ph <= 3'h0;
        else ph <= {tk && !hwrite, tk && hwrite, haddr[11:0] == EVENT_FLAGS_OFFSET};
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    ready_always_a: assert property (hreadyout) else $error("not ready");
    resp_okay_a: assert property (hresp == HRESP_OKAY) else $error("bad resp");
    read_idle_a: assert property (!ph[2] |-> hrdata == 32'h0) else $error("stray");
    flag_upper_a: assert property (ph[2] && ph[0] |-> hrdata[31:UNITS] == '0) else
        $error("upper bits set");
    reset_irq_a: assert property ($rose(reset_n) |-> !interruptRequest) else
        $error("request after reset");
    irq_fall_a: assert property ($fell(interruptRequest) |->
        $past(ph[1]) || $past(ph[1], 2)) else $error("request fell alone");
    irq_rise_a: assert property ($rose(interruptRequest) |-> $past(|unitEvents) ||
        $past(|unitEvents, 2) || $past(ph[1]) || $past(ph[1], 2)) else $error("no cause");
    irq_hold_a: assert property (interruptRequest && !ph[1] && !$past(ph[1]) |=>
        interruptRequest) else $error("request dropped");
    cover property ($rose(interruptRequest));
    cover property ($fell(interruptRequest));
    cover property (ph[2] && ph[0] && hrdata != 32'h0);
endmodule
bind capture_unit_irq_flags capture_irq_sva #(.UNITS(UNITS)) sva (.clock, .reset_n, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .unitEvents,
    .interruptRequest);
`default_nettype wire

// *** test/unit_model.sv ***
// five unit event sources
// assumes fire is called just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module unit_model (
    // units to flag block
    input wire logic clock,
    output var capture_irq_pkg::unit_events_type unitEvents
);
    import capture_irq_pkg::*;
    initial unitEvents = '0;
    task automatic fire(input int u, input unit_mode_type k);
        @(posedge clock);
        case (k)
            MODE_CAPTURE: unitEvents.capture[u] <= 1'b1;
            MODE_COMPARE: unitEvents.match[u] <= 1'b1;
            default: unitEvents.pulseOut[u] <= 1'b1;
        endcase
        @(posedge clock);
        unitEvents <= '0;
    endtask
endmodule
`default_nettype wire

// *** test/capture_unit_irq_flags_tb.sv ***
// bench for the capture flag block
// assumes the unit model drives the event strobes
`timescale 1ns/1ps
`default_nettype none
module capture_unit_irq_flags_tb;
    import capture_irq_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] hresp;
    logic hready, irq;
    unit_events_type unitEvents;
    int failCount = 0, checked = 0;
    initial forever #50 clock = ~clock;
    unit_model units (.clock, .unitEvents);
    capture_unit_irq_flags DUT (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .unitEvents,
        .interruptRequest(irq));
    task automatic chk(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        failCount++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        rd(EVENT_FLAGS_OFFSET, 32'h0);
        for (int u = 0; u < UNIT_COUNT; u++) begin
            for (int m = 0; m < 4; m++) begin
                xfer(1'b1, UNIT_MODE_OFFSET, 32'(m) << (2 * u));
                units.fire(u, unit_mode_type'(m));
                rd(EVENT_FLAGS_OFFSET, (m == 0) ? 32'h0 : 32'h1 << u);
                xfer(1'b1, EVENT_FLAGS_OFFSET, 32'h0);
                rd(EVENT_FLAGS_OFFSET, 32'h0);
            end
        end
        units.fire(4, MODE_PULSE);
        xfer(1'b1, EVENT_FLAGS_OFFSET, 32'hFFFF_FFFF);
        xfer(1'b1, UNIT_ENABLE_OFFSET, 32'h0000_0010);
        xfer(1'b1, INT_CONTROL_OFFSET, 32'h0000_0080);
        rd(EVENT_FLAGS_OFFSET, 32'h0000_0010);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, INT_CONTROL_OFFSET, 32'h0000_00C0);
        rd(UNIT_ENABLE_OFFSET, 32'h0000_0010);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, UNIT_MODE_OFFSET, 32'h0000_0100);
        fork
            xfer(1'b1, EVENT_FLAGS_OFFSET, 32'h0);
            begin
                @(posedge clock);
                units.fire(4, MODE_CAPTURE);
            end
        join
        rd(EVENT_FLAGS_OFFSET, 32'h0000_0010);
        xfer(1'b1, UNIT_ENABLE_OFFSET, 32'h0);
        rd(12'h010, 32'h0);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, EVENT_FLAGS_OFFSET, 32'h0);
        xfer(1'b1, UNIT_ENABLE_OFFSET, 32'h0000_0010);
        rd(EVENT_FLAGS_OFFSET, 32'h0);
        chk({31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
